// [wiper_defines.vh]
// What this block does
// - 24-bit frames; low 16 bits carry data
// - Echo previous frame on serial out
// - Code 0xB loads low 10 bits
// - Code 0xE0 increments wiper by one
// - Code 0x20 stores wiper to location 0
// - Write-protect low blocks nonvolatile writes
// - Reload wiper at power-on, strobe, command
// - Code 0x10 restores location 0 to wiper
// - Code 0xC0 doubles the wiper
// - Doubling midscale gives full scale
// - Code 0x3 stores data at address nibble 1-15
// - Code 0x9 reads location next frame
// - NOP after read ends read mode
// - Code 0xA0 returns wiper next frame
// - Location 0 wiper, 1 outputs, 2-15 user
// - Restore copies stored output bits out
// Purpose: constants for the wiper command interpreter
// Assumes: plain Verilog-2005 includers
// Notes:   definitions only
`ifndef WIPER_DEFINES_VH
`define WIPER_DEFINES_VH
`define FRAME_BITS     24
`define WIPER_MAX      10'h3ff
`define WIPER_MID      10'h200
`define CMD_NOP        4'h0
`define CMD_RESTORE    4'h1
`define CMD_STORE      4'h2
`define CMD_USER_WR    4'h3
`define CMD_RESTORE_B  4'h8
`define CMD_READ_NV    4'h9
`define CMD_READ_WIPER 4'ha
`define CMD_LOAD       4'hb
`define CMD_DOUBLE     4'hc
`define CMD_INC        4'he
`define ADDR_WIPER     4'h0
`define ADDR_OUTPUTS   4'h1
`define OUT1_BIT       0
`define OUT2_BIT       1
`endif

// [nonvolatile_store.v]
// Purpose: sixteen-word nonvolatile store model
// Assumes: single clock, one access per cycle
// Notes:   contents are not reset, they persist
`timescale 1ns/100ps
module nonvolatile_store #(
    parameter WORDS = 16,
    parameter AW    = 4
) (
    // Clock
    input  wire          mclk,
    // Access
    input  wire          writeEnable,
    input  wire          writeProtectN,
    input  wire          readEnable,
    input  wire [AW-1:0] address,
    input  wire [15:0]   writeData,
    output reg  [15:0]   readData
);
    reg [15:0] cells [0:WORDS-1]; // Stored words
    integer i;

    // Blank part starts all zero
    initial begin
        for (i = 0; i < WORDS; i = i + 1) begin
            cells[i] = 16'h0000;
        end
    end

    // Writes refused while protect is low, reads one cycle late
    always @(posedge mclk) begin
        if (writeEnable && writeProtectN) begin
            cells[address] <= writeData;
        end
        if (readEnable) begin
            readData <= cells[address];
        end
    end
endmodule // nonvolatile_store

// [serial_frame_port.v]
// Purpose: three-wire serial shifter with frame echo
// Assumes: pins synchronous to mclk, MSB first
// Notes:   sample on clock rise, shift out on fall
`timescale 1ns/100ps
`include "wiper_defines.vh"
module serial_frame_port (
    // Clock and reset
    input  wire        mclk,
    input  wire        resetn,
    // Serial pins
    input  wire        chipSelectN,
    input  wire        serialClock,
    input  wire        serialDataIn,
    output reg         serialDataOut,
    output reg         serialOutEnable,
    // Word side
    input  wire [23:0] echoWord,
    output reg         frameValid,
    output reg  [23:0] frameWord
);
    reg        csPrev;    // Select one cycle ago
    reg        clkPrev;   // Serial clock one cycle ago
    reg [4:0]  bitCount;  // Saturates at 31
    reg [23:0] inShift;   // Incoming bits
    reg [23:0] outShift;  // Outgoing bits
    wire csFall = csPrev & ~chipSelectN;
    wire csRise = ~csPrev & chipSelectN;
    wire sckRise = ~clkPrev & serialClock & ~chipSelectN;
    wire sckFall = clkPrev & ~serialClock & ~chipSelectN;

    // Shifting, counting and frame completion
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            csPrev <= 1'b1;
            clkPrev <= 1'b0;
            bitCount <= 5'h00;
            inShift <= 24'h000000;
            outShift <= 24'h000000;
            serialDataOut <= 1'b0;
            serialOutEnable <= 1'b0;
            frameValid <= 1'b0;
            frameWord <= 24'h000000;
        end else begin
            csPrev <= chipSelectN;
            clkPrev <= serialClock;
            frameValid <= 1'b0;
            serialOutEnable <= ~chipSelectN;
            if (csFall) begin
                // Last frame goes out while this one comes in
                bitCount <= 5'h00;
                outShift <= {echoWord[22:0], 1'b0};
                serialDataOut <= echoWord[23];
            end else if (sckRise) begin
                inShift <= {inShift[22:0], serialDataIn};
                if (bitCount != 5'h1f) begin
                    bitCount <= bitCount + 5'h01;
                end
            end else if (sckFall) begin
                serialDataOut <= outShift[23];
                outShift <= {outShift[22:0], 1'b0};
            end
            // Short or long frames are dropped
            if (csRise && bitCount == `FRAME_BITS) begin
                frameValid <= 1'b1;
                frameWord <= inShift;
            end
        end
    end
endmodule // serial_frame_port

// [wiper_command_interpreter.v]
// Purpose: decode serial frames into wiper and memory actions
// Assumes: reset marks power-on; pins synchronous to mclk
// Notes:   one command executes per completed frame;
//          restores always win over a frame finishing at the same time,
//          and a restore asked for mid-sequence is queued, not dropped
`timescale 1ns/100ps
`include "wiper_defines.vh"
module wiper_command_interpreter (
    // Clock and reset
    input  wire       mclk,
    input  wire       resetn,
    // Serial port
    input  wire       chipSelectN,
    input  wire       serialClock,
    input  wire       serialDataIn,
    output wire       serialDataOut,
    output wire       serialOutEnable,
    // Control pins
    input  wire       writeProtectN,
    input  wire       presetRestoreN,
    // Wiper and digital outputs
    output reg  [9:0] wiperSetting,
    output reg        firstDigitalOutput,
    output reg        secondDigitalOutput,
    // Status
    output reg        readModeActive,
    output reg        restoreBusy
);
    // Restore sequencer states. A restore reads the wiper word, then the
    // output word; each read returns one cycle after its strobe, so the
    // sequence costs three cycles from request to outputs settled.
    // Read-back of a user word borrows the same machine for one cycle.
    localparam ST_IDLE  = 2'b00; // Nothing in flight
    localparam ST_RD0   = 2'b01; // Wiper word read issued
    localparam ST_RD1   = 2'b10; // Output word read issued
    localparam ST_USER  = 2'b11; // User word read issued

    // Frame side: the shifter hands over a whole frame at once, so the
    // decode below never sees a partial word or a half-shifted command
    // nibble
    wire        frameValid;  // One-cycle pulse per good frame
    wire [23:0] frameWord;   // Received frame
    wire [3:0]  command;     // Top nibble
    wire [3:0]  cmdAddress;  // Address nibble
    wire [15:0] cmdData;     // Data field

    // Echo path: the host sees the last frame back, or read-back data in
    // the low half when the last frame asked for it
    reg  [23:0] prevFrame;    // Last frame received
    reg         readbackHit;  // Low half replaced by readback
    reg  [15:0] readbackWord; // Data for the next echo
    wire [23:0] echoWord;     // Word sent during next frame

    // Memory access: at most one strobe per cycle, decided in one place,
    // so a write and a read never meet on the same address
    reg         memWrite;      // Write strobe
    reg         memRead;       // Read strobe
    reg  [3:0]  memAddr;       // Word address
    reg  [15:0] memWriteData;  // Word written
    wire [15:0] memReadData;   // Word read, one cycle late

    // Sequencer
    reg  [1:0]  state;         // Current state
    reg  [1:0]  next_state;    // Next state
    reg         powerOnPending; // Set by reset, cleared when started
    reg         restoreQueued;  // Restore asked for while busy
    reg         presetPrev;    // Restore pin one cycle ago
    wire        presetFall;    // Restore strobe edge
    wire        restoreCmd;    // Restore-all frame decoded
    wire        startRestore;  // Any restore source

    // Wiper arithmetic, worked out every cycle so that a frame can use
    // the result in the cycle it is decoded
    reg  [9:0]  wiperInc;      // Incremented, saturated
    reg  [9:0]  wiperDouble;   // Doubled, saturated

    // Field split of a frame: command nibble, address nibble, data half.
    // Unused fields of a command are simply ignored, never checked.
    assign command = frameWord[23:20];
    assign cmdAddress = frameWord[19:16];
    assign cmdData = frameWord[15:0];
    assign echoWord = readbackHit ? {prevFrame[23:16], readbackWord} : prevFrame;
    assign presetFall = presetPrev & ~presetRestoreN;
    assign restoreCmd = frameValid && (command == `CMD_RESTORE || command == `CMD_RESTORE_B);
    // Power-on, the strobe pin, a restore frame or a queued request all
    // start the very same two-read sequence
    assign startRestore = powerOnPending | restoreQueued | presetFall | restoreCmd;

    // Serial shifter: it owns the pins, counts serial clocks and refuses
    // any frame that is not exactly 24 clocks long; it copies the echo
    // word at the select fall
    serial_frame_port port (
        .mclk            (mclk),
        .resetn          (resetn),
        .chipSelectN     (chipSelectN),
        .serialClock     (serialClock),
        .serialDataIn    (serialDataIn),
        .serialDataOut   (serialDataOut),
        .serialOutEnable (serialOutEnable),
        .echoWord        (echoWord),
        .frameValid      (frameValid),
        .frameWord       (frameWord)
    );

    // Nonvolatile words: address 0 for the wiper, address 1 for the two
    // output bits, the rest free for the user. Write protect is applied
    // inside the store, so every writer obeys it.
    nonvolatile_store #(
        .WORDS (16),
        .AW    (4)
    ) store (
        .mclk          (mclk),
        .writeEnable   (memWrite),
        .writeProtectN (writeProtectN),
        .readEnable    (memRead),
        .address       (memAddr),
        .writeData     (memWriteData),
        .readData      (memReadData)
    );

    // Saturating step and doubling, never wrap to zero. A wrap would throw
    // the wiper from full scale to zero scale in one step, which is the
    // worst possible surprise for whatever the divider feeds.
    always @* begin
        if (wiperSetting == `WIPER_MAX) begin
            wiperInc = `WIPER_MAX;
        end else begin
            wiperInc = wiperSetting + 10'h001;
        end
        if (wiperSetting >= `WIPER_MID) begin
            wiperDouble = `WIPER_MAX;
        end else begin
            wiperDouble = {wiperSetting[8:0], 1'b0};
        end
    end

    // Memory strobes for stores, restores and reads. Priority: second read
    // of a restore, then a new restore, then the frame's own access. A store
    // or read frame that lands while the sequencer is busy is dropped; the
    // host spacing between frames keeps this from happening in practice.
    always @* begin
        memWrite = 1'b0;
        memRead = 1'b0;
        memAddr = `ADDR_WIPER;
        memWriteData = 16'h0000;
        if (state == ST_RD0) begin
            // Second word of a restore: digital output bits
            memRead = 1'b1;
            memAddr = `ADDR_OUTPUTS;
        end else if (startRestore && state == ST_IDLE) begin
            memRead = 1'b1;
            memAddr = `ADDR_WIPER;
        end else if (frameValid && state == ST_IDLE) begin
            case (command)
                `CMD_STORE: begin
                    memWrite = 1'b1;
                    memAddr = `ADDR_WIPER;
                    memWriteData = {6'h00, wiperSetting};
                end
                `CMD_USER_WR: begin
                    // Address 0 belongs to the wiper store only
                    // Address 1 may be written here to preset the output bits
                    memWrite = (cmdAddress != `ADDR_WIPER);
                    memAddr = cmdAddress;
                    memWriteData = cmdData;
                end
                `CMD_READ_NV: begin
                    // Data comes back next cycle; the user state takes it
                    memRead = 1'b1;
                    memAddr = cmdAddress;
                end
                default: begin
                    memRead = 1'b0;
                end
            endcase
        end
    end

    // Sequencer next state. Every state but idle lasts exactly one cycle,
    // so busy time is fixed and easy to check from outside.
    always @* begin
        case (state)
            ST_IDLE: begin
                // A restore outranks a read frame arriving in the same cycle
                if (startRestore) begin
                    next_state = ST_RD0;
                end else if (frameValid && command == `CMD_READ_NV) begin
                    next_state = ST_USER;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_RD0: begin
                next_state = ST_RD1;
            end
            ST_RD1: begin
                next_state = ST_IDLE;
            end
            ST_USER: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Sequencer state, power-on request and strobe edge
    // The strobe edge detector idles high like the pin, so reset gives no false restore
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            powerOnPending <= 1'b1;
            restoreQueued <= 1'b0;
            presetPrev <= 1'b1;
            restoreBusy <= 1'b0;
        end else begin
            state <= next_state;
            presetPrev <= presetRestoreN;
            if (state == ST_IDLE) begin
                // Taken as soon as the sequencer is free
                powerOnPending <= 1'b0;
                restoreQueued <= 1'b0;
            end else if (presetFall || restoreCmd) begin
                // Strobe or frame seen mid-sequence: run once more after
                restoreQueued <= 1'b1;
            end
            // Busy follows the next state so it lines up with the reads
            restoreBusy <= (next_state == ST_RD0) || (next_state == ST_RD1);
        end
    end

    // Wiper register and digital output register. Restore data wins over
    // any frame; the outputs change only on the second read of a restore.
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wiperSetting <= 10'h000;
            firstDigitalOutput <= 1'b0;
            secondDigitalOutput <= 1'b0;
        end else if (state == ST_RD0) begin
            // Stored wiper lands one cycle after its read
            wiperSetting <= memReadData[9:0];
        end else if (state == ST_RD1) begin
            // Output bits land one cycle after the wiper
            firstDigitalOutput <= memReadData[`OUT1_BIT];
            secondDigitalOutput <= memReadData[`OUT2_BIT];
        end else if (frameValid) begin
            // Frames arriving during a restore lose to it
            case (command)
                `CMD_LOAD: begin
                    wiperSetting <= cmdData[9:0];
                end
                `CMD_INC: begin
                    wiperSetting <= wiperInc;
                end
                `CMD_DOUBLE: begin
                    wiperSetting <= wiperDouble;
                end
                default: begin
                    // Other commands leave the wiper alone
                    wiperSetting <= wiperSetting;
                end
            endcase
        end
    end

    // Echo word for the next frame. The shifter copies it at the select
    // fall, so it must be settled before then; the host spacing between
    // frames leaves several cycles after the one-cycle memory read.
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prevFrame <= 24'h000000;
            readbackHit <= 1'b0;
            readbackWord <= 16'h0000;
        end else if (frameValid) begin
            prevFrame <= frameWord;
            if (command == `CMD_READ_WIPER) begin
                readbackHit <= 1'b1;
                readbackWord <= {6'h00, wiperSetting};
            end else begin
                // Read result arrives a cycle later below
                readbackHit <= (command == `CMD_READ_NV);
                readbackWord <= 16'h0000;
            end
        end else if (state == ST_USER) begin
            // Memory data arrives one cycle after the read strobe
            readbackWord <= memReadData;
        end
    end

    // Read mode lasts until a no-operation frame. It only reports the
    // higher-power state to the outside; no logic here depends on it,
    // so a host that never sends the no-operation frame loses nothing
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            readModeActive <= 1'b0;
        end else if (frameValid) begin
            if (command == `CMD_NOP) begin
                readModeActive <= 1'b0;
            end else if (command == `CMD_READ_NV || restoreCmd) begin
                readModeActive <= 1'b1;
            end
        end
    end
endmodule // wiper_command_interpreter

// [wiper_checker_asserts.sv]
// Purpose: port-level checks on the wiper command interpreter
// Assumes: one clock domain, reset low marks power-on
// Notes:   bound to the design top after the module
`timescale 1ns/100ps
module wiper_checker (
    // Clock and reset
    input wire       mclk,
    input wire       resetn,
    // Serial port
    input wire       chipSelectN,
    input wire       serialClock,
    input wire       serialDataOut,
    input wire       serialOutEnable,
    // Results
    input wire [9:0] wiperSetting,
    input wire       firstDigitalOutput,
    input wire       secondDigitalOutput,
    input wire       readModeActive,
    input wire       restoreBusy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // A restore holds busy for exactly two cycles
    sequence busy_run;
        restoreBusy ##1 !restoreBusy;
    endsequence
    // End of a frame, select released
    sequence frame_end;
        $rose(chipSelectN);
    endsequence
    a_enable_tracks_select: assert property (serialOutEnable == !$past(chipSelectN))
        else $error("output enable does not follow select");
    a_enable_drop_end: assert property (frame_end |=> !serialOutEnable [*2])
        else $error("output enable stays up after frame");
    a_wiper_only_decoded: assert property ($changed(wiperSetting) |-> $past(chipSelectN) || $past(restoreBusy))
        else $error("wiper moved inside a frame");
    a_read_mode_set: assert property ($rose(readModeActive) |-> $past(chipSelectN))
        else $error("read mode set without frame");
    a_read_mode_clear: assert property ($fell(readModeActive) |-> $past(chipSelectN))
        else $error("read mode cleared without frame");
    a_restore_two_cycles: assert property ($rose(restoreBusy) |=> busy_run)
        else $error("restore busy length wrong");
    a_outputs_on_restore: assert property (($changed(firstDigitalOutput) || $changed(secondDigitalOutput))
        |-> $past(restoreBusy) || $past(restoreBusy, 2))
        else $error("digital outputs moved outside restore");
    a_echo_bit_hold: assert property (($changed(serialDataOut) && serialOutEnable && $past(serialOutEnable))
        |-> !$past(serialClock))
        else $error("echo bit changed while serial clock high");
endmodule // wiper_checker
bind wiper_command_interpreter wiper_checker u_chk (.mclk(mclk), .resetn(resetn),
    .chipSelectN(chipSelectN), .serialClock(serialClock), .serialDataOut(serialDataOut),
    .serialOutEnable(serialOutEnable), .wiperSetting(wiperSetting),
    .firstDigitalOutput(firstDigitalOutput), .secondDigitalOutput(secondDigitalOutput),
    .readModeActive(readModeActive), .restoreBusy(restoreBusy));

// [host_serial.sv]
// Purpose: host side of the three-wire serial port
// Assumes: tasks entered just after a rising mclk edge
// Notes:   serial clock stands still outside frames
`timescale 1ns/100ps
module host_serial (
    // Clock
    input  wire mclk,
    // Serial pins
    output reg  chipSelectN,
    output reg  serialClock,
    output reg  serialDataIn,
    input  wire serialDataOut
);
    // Idle levels at time zero
    initial begin
        chipSelectN  = 1'b1;
        serialClock  = 1'b0;
        serialDataIn = 1'b0;
    end
    // Wait n rising edges
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Send n bits MSB first; echo bit taken before each rise
    task automatic send(input [23:0] w, input int n, output [23:0] e);
        e = 24'h000000;
        chipSelectN <= 1'b0;
        for (int i = 23; i > 23 - n; i--) begin
            serialDataIn <= w[i];
            tick(4); // Low phase long enough for the echo bit to settle
            e[i] = serialDataOut;
            serialClock <= 1'b1;
            tick(2);
            serialClock <= 1'b0;
        end
        tick(2);
        chipSelectN  <= 1'b1;
        serialDataIn <= ~serialDataIn; // Released line shows no stale value
        tick(6); // Spacing covers execute and wiper update
    endtask
endmodule // host_serial

// [tb.sv]
// Purpose: self-checking bench for the wiper command interpreter
// Assumes: nonvolatile store starts all zero
// Notes:   scenarios run in order and share stored state
`timescale 1ns/100ps
module tb;
    // Clock, reset and control pins
    reg        mclk           = 1'b0;
    reg        resetn         = 1'b0;
    reg        writeProtectN  = 1'b1;
    reg        presetRestoreN = 1'b1;
    // Design pins
    wire       chipSelectN;
    wire       serialClock;
    wire       serialDataIn;
    wire       serialDataOut;
    wire       serialOutEnable;
    wire [9:0] wiperSetting;
    wire       firstDigitalOutput;
    wire       secondDigitalOutput;
    wire       readModeActive;
    wire       restoreBusy;
    // Bookkeeping
    int        err_total = 0;
    int        checks    = 0;
    reg [23:0] echo;
    always #25 mclk = ~mclk;
    host_serial host (.mclk(mclk), .chipSelectN(chipSelectN), .serialClock(serialClock),
        .serialDataIn(serialDataIn), .serialDataOut(serialDataOut));
    wiper_command_interpreter uut (.mclk(mclk), .resetn(resetn), .chipSelectN(chipSelectN),
        .serialClock(serialClock), .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
        .serialOutEnable(serialOutEnable), .writeProtectN(writeProtectN),
        .presetRestoreN(presetRestoreN), .wiperSetting(wiperSetting),
        .firstDigitalOutput(firstDigitalOutput), .secondDigitalOutput(secondDigitalOutput),
        .readModeActive(readModeActive), .restoreBusy(restoreBusy));
    // Compare any result word
    task automatic cmp(input [23:0] got, input [23:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One full frame, echo kept
    task automatic frame(input [23:0] w);
        host.send(w, 24, echo);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic t_load;
        cmp(wiperSetting, 24'h000000);
        frame(24'hb00100); cmp(wiperSetting, 24'h000100);
        cmp(echo, 24'h000000);
        frame(24'he00000); cmp(echo, 24'hb00100);
        cmp(wiperSetting, 24'h000101);
        frame(24'he00000); cmp(echo, 24'he00000);
        cmp(wiperSetting, 24'h000102);
        done("load");
    endtask
    task automatic t_store;
        frame(24'h200000); frame(24'hb00000);
        frame(24'h100000); cmp(wiperSetting, 24'h000102);
        cmp(readModeActive, 24'h000001);
        frame(24'h000000); cmp(echo, 24'h100000);
        cmp(readModeActive, 24'h000000);
        done("store");
    endtask
    task automatic t_double;
        frame(24'hb00200); frame(24'hc00000); cmp(wiperSetting, 24'h0003ff);
        frame(24'hc00000); cmp(wiperSetting, 24'h0003ff);
        frame(24'he00000); cmp(wiperSetting, 24'h0003ff);
        frame(24'ha00000); frame(24'h000000); cmp(echo, 24'ha003ff);
        done("double");
    endtask
    task automatic t_user;
        frame(24'h32aaaa); frame(24'h3f5555); cmp(echo, 24'h32aaaa);
        frame(24'h920000); frame(24'h000000); cmp(echo, 24'h92aaaa);
        frame(24'h9f0000); frame(24'h000000); cmp(echo, 24'h9f5555);
        frame(24'h310003); frame(24'hb00000); frame(24'h800000); frame(24'h000000);
        cmp({secondDigitalOutput, firstDigitalOutput}, 24'h000003);
        cmp(wiperSetting, 24'h000102);
        done("user");
    endtask
    task automatic t_protect;
        writeProtectN <= 1'b0;
        frame(24'hb00055); frame(24'h200000); frame(24'h32bbbb);
        frame(24'h100000); frame(24'h000000); cmp(wiperSetting, 24'h000102);
        frame(24'h920000); frame(24'h000000); cmp(echo, 24'h92aaaa);
        writeProtectN <= 1'b1;
        done("protect");
    endtask
    task automatic t_strobe;
        frame(24'hb00011);
        presetRestoreN <= 1'b0;
        host.tick(2);
        presetRestoreN <= 1'b1;
        host.tick(6);
        cmp(wiperSetting, 24'h000102);
        done("strobe");
    endtask
    task automatic t_short;
        frame(24'hb00077);
        host.send(24'hb00001, 23, echo); // Frame one clock short
        cmp(wiperSetting, 24'h000077);
        done("short");
    endtask
    task automatic t_reset;
        frame(24'h310001);
        resetn <= 1'b0;
        host.tick(2);
        resetn <= 1'b1;
        host.tick(6); // Power-on restore needs three cycles
        cmp(wiperSetting, 24'h000102);
        cmp({secondDigitalOutput, firstDigitalOutput}, 24'h000001);
        frame(24'hb00000); cmp(echo, 24'h000000);
        done("reset");
    endtask
    // Verdict and end of run
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        host.tick(6);
        t_load;
        t_store;
        t_double;
        t_user;
        t_protect;
        t_strobe;
        t_short;
        t_reset;
        conclude;
    end
    // Watchdog: about four times the expected run
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        conclude;
    end
endmodule // tb
